// [aip_defines.vh]
`ifndef AIP_DEFINES_VH
`define AIP_DEFINES_VH

// register layout of the interrupt status and control word
`define AIP_REG_WIDTH        16
`define AIP_RESET_VALUE      16'h0000
// enable bits
`define AIP_BIT_RX_IE        0
`define AIP_BIT_RXERR_IE     1
`define AIP_BIT_TX_IE        2
`define AIP_BIT_TXERR_IE     3
// pending flags
`define AIP_BIT_RX_IP        4
`define AIP_BIT_RXERR_IP     5
`define AIP_BIT_TX_IP        6
`define AIP_BIT_TXERR_IP     7
// clear bits
`define AIP_BIT_RX_IC        8
`define AIP_BIT_RXERR_IC     9
`define AIP_BIT_TX_IC        10
`define AIP_BIT_TXERR_IC     11
`define AIP_NUM_SRC          4

`endif

// [aip_irq_pending_clear.v]
// Functional notes
// R1: the receive pending flag holds while a receive interrupt is outstanding and clears on a 1 written to its clear bit.
// R2: the receive error pending flag holds likewise and clears on a 1 written to the receive error clear bit.
// R3: the transmit pending flag holds likewise and clears on a 1 written to the transmit clear bit.
// R4: the transmit error pending flag holds likewise and clears on a 1 written to the transmit error clear bit.
// R5: pending flags are read-only; a write affects them only through the clear bits.
// R6: a 0 written to a clear bit leaves its pending flag alone.
// R7: each pending flag reads 1 while its source is pending and 0 otherwise.
// R8: with transmit interrupts enabled, a rising almost-empty condition raises a transmit interrupt.
// R9: with receive error interrupts enabled, a rising overrun condition raises a receive error interrupt.
// R10: reset clears all pending flags and all enable bits.
// R11: a new event in the same cycle as its clear keeps the flag set, and clear bits read back as 0.
`timescale 1ns/100ps
`default_nettype none
`include "aip_defines.vh"

module aip_irq_pending_clear (
    input  wire        sys_clk,
    input  wire        reset,
    input  wire        reg_wr,
    input  wire [15:0] reg_wdata,
    output reg  [15:0] reg_rdata,
    input  wire        receive_event,
    input  wire        receive_overrun_condition,
    input  wire        transmit_almost_empty,
    input  wire        transmit_underrun_condition,
    output wire        audio_irq
);

    // ----------------------------------------------------------------
    // declarations
    // ----------------------------------------------------------------
    reg  [3:0]  enable_q;
    wire [3:0]  enable_d;

    reg         overrun_prev_q;
    reg         almost_empty_prev_q;
    reg         underrun_prev_q;

    wire        rx_raw;
    wire        rxerr_raw;
    wire        tx_raw;
    wire        txerr_raw;
    wire        rx_set;
    wire        rxerr_set;
    wire        tx_set;
    wire        txerr_set;
    wire        rx_clear;
    wire        rxerr_clear;
    wire        tx_clear;
    wire        txerr_clear;

    reg         rx_pending_q;
    reg         rx_pending_d;
    reg         rxerr_pending_q;
    reg         rxerr_pending_d;
    reg         tx_pending_q;
    reg         tx_pending_d;
    reg         txerr_pending_q;
    reg         txerr_pending_d;
    wire [3:0]  pending_q;
    wire [3:0]  pending_d;
    wire [15:0] reg_rdata_d;

    // ----------------------------------------------------------------
    // enable bits
    // ----------------------------------------------------------------
    // every write carries the enables, so the field is taken whole
    assign enable_d = reg_wr ? reg_wdata[`AIP_BIT_TXERR_IE:`AIP_BIT_RX_IE] : enable_q;

    always @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            enable_q <= 4'h0; // R10
        end else begin
            enable_q <= enable_d;
        end
    end

    // ----------------------------------------------------------------
    // receive source: every high cycle of the request is an event
    // ----------------------------------------------------------------
    assign rx_raw   = receive_event;
    assign rx_set   = rx_raw & enable_q[`AIP_BIT_RX_IE];
    assign rx_clear = reg_wr & reg_wdata[`AIP_BIT_RX_IC]; // R5 R6

    // set is applied after clear so that a same-cycle event wins
    always @* begin
        rx_pending_d = rx_pending_q;
        if (rx_clear) begin
            rx_pending_d = 1'b0; // R1
        end
        if (rx_set) begin
            rx_pending_d = 1'b1; // R11
        end
    end

    always @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            rx_pending_q <= 1'b0; // R10
        end else begin
            rx_pending_q <= rx_pending_d;
        end
    end

    // ----------------------------------------------------------------
    // receive error source: rising edge of the overrun condition
    // ----------------------------------------------------------------
    // the edge flops reset low; the enables are low after reset too,
    // so a condition already high at release raises nothing
    always @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            overrun_prev_q <= 1'b0;
        end else begin
            overrun_prev_q <= receive_overrun_condition;
        end
    end

    assign rxerr_raw   = receive_overrun_condition & ~overrun_prev_q; // R9
    assign rxerr_set   = rxerr_raw & enable_q[`AIP_BIT_RXERR_IE];     // R9
    assign rxerr_clear = reg_wr & reg_wdata[`AIP_BIT_RXERR_IC];       // R5 R6

    always @* begin
        rxerr_pending_d = rxerr_pending_q;
        if (rxerr_clear) begin
            rxerr_pending_d = 1'b0; // R2
        end
        if (rxerr_set) begin
            rxerr_pending_d = 1'b1; // R11
        end
    end

    always @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            rxerr_pending_q <= 1'b0; // R10
        end else begin
            rxerr_pending_q <= rxerr_pending_d;
        end
    end

    // ----------------------------------------------------------------
    // transmit source: rising edge of the almost-empty condition
    // ----------------------------------------------------------------
    always @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            almost_empty_prev_q <= 1'b0;
        end else begin
            almost_empty_prev_q <= transmit_almost_empty;
        end
    end

    assign tx_raw   = transmit_almost_empty & ~almost_empty_prev_q; // R8
    assign tx_set   = tx_raw & enable_q[`AIP_BIT_TX_IE];            // R8
    assign tx_clear = reg_wr & reg_wdata[`AIP_BIT_TX_IC];           // R5 R6

    always @* begin
        tx_pending_d = tx_pending_q;
        if (tx_clear) begin
            tx_pending_d = 1'b0; // R3
        end
        if (tx_set) begin
            tx_pending_d = 1'b1; // R11
        end
    end

    always @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            tx_pending_q <= 1'b0; // R10
        end else begin
            tx_pending_q <= tx_pending_d;
        end
    end

    // ----------------------------------------------------------------
    // transmit error source: rising edge of the underrun condition
    // ----------------------------------------------------------------
    always @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            underrun_prev_q <= 1'b0;
        end else begin
            underrun_prev_q <= transmit_underrun_condition;
        end
    end

    assign txerr_raw   = transmit_underrun_condition & ~underrun_prev_q;
    assign txerr_set   = txerr_raw & enable_q[`AIP_BIT_TXERR_IE];
    assign txerr_clear = reg_wr & reg_wdata[`AIP_BIT_TXERR_IC]; // R5 R6

    always @* begin
        txerr_pending_d = txerr_pending_q;
        if (txerr_clear) begin
            txerr_pending_d = 1'b0; // R4
        end
        if (txerr_set) begin
            txerr_pending_d = 1'b1; // R11
        end
    end

    always @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            txerr_pending_q <= 1'b0; // R10
        end else begin
            txerr_pending_q <= txerr_pending_d;
        end
    end

    // ----------------------------------------------------------------
    // read back
    // ----------------------------------------------------------------
    assign pending_q = {txerr_pending_q, tx_pending_q, rxerr_pending_q, rx_pending_q};
    assign pending_d = {txerr_pending_d, tx_pending_d, rxerr_pending_d, rx_pending_d};

    // clear bits and the reserved field read as 0
    assign reg_rdata_d = {8'h00, pending_d, enable_d}; // R7 R11

    always @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            reg_rdata <= `AIP_RESET_VALUE; // R10
        end else begin
            reg_rdata <= reg_rdata_d;
        end
    end

    // ----------------------------------------------------------------
    // interrupt line
    // ----------------------------------------------------------------
    assign audio_irq = |pending_q;

endmodule // aip_irq_pending_clear
`default_nettype wire

// [aip_irq_assertions.sv]
`timescale 1ns/100ps
`default_nettype none
module aip_chk (
    input wire logic        sys_clk,
    input wire logic        reset,
    input wire logic        reg_wr,
    input wire logic [15:0] reg_wdata,
    input wire logic [15:0] reg_rdata,
    input wire logic        receive_event,
    input wire logic        receive_overrun_condition,
    input wire logic        transmit_almost_empty,
    input wire logic        transmit_underrun_condition,
    input wire logic        audio_irq
);
    wire [15:0] r  = reg_rdata;
    wire [15:0] w  = reg_wdata;
    wire        rx = receive_event;
    wire        ov = receive_overrun_condition;
    wire        ta = transmit_almost_empty;
    wire        un = transmit_underrun_condition;

    default clocking @(posedge sys_clk); endclocking
    default disable iff (reset);

    AST_RX: assert property (r[0] && rx |=> r[4]) else $error("receive event lost");
    AST_RXE: assert property (r[1] && $rose(ov) |=> r[5]) else $error("receive error event lost");
    AST_TX: assert property (r[2] && $rose(ta) |=> r[6]) else $error("transmit event lost");
    AST_TXE: assert property (r[3] && $rose(un) |=> r[7]) else $error("transmit error event lost");
    AST_CLR: assert property (reg_wr && w[10] && !ta |=> !r[6]) else $error("transmit flag not cleared");
    AST_NOSET: assert property (!r[4] && !rx |=> !r[4]) else $error("receive flag set without event");
    AST_EN: assert property (reg_wr |=> r[3:0]==$past(w[3:0]) && r[15:8]==8'h00) else $error("readback");
    AST_IRQ: assert property (audio_irq == |r[7:4]) else $error("interrupt line differs from flags");
    AST_RST: assert property (@(posedge sys_clk) disable iff (1'b0) reset |=> r==16'h0000) else $error("reset");

    cover property (r[6] && reg_wr && w[10]);
    cover property (r[0] && rx && reg_wr && w[8]);
    cover property (r[7:4] == 4'hF);
    cover property (r[7:4] == 4'h4 && r[3:0] == 4'h4);
endmodule // aip_chk

bind aip_irq_pending_clear aip_chk aip_chk_i (
    .sys_clk                     (sys_clk),
    .reset                       (reset),
    .reg_wr                      (reg_wr),
    .reg_wdata                   (reg_wdata),
    .reg_rdata                   (reg_rdata),
    .receive_event               (receive_event),
    .receive_overrun_condition   (receive_overrun_condition),
    .transmit_almost_empty       (transmit_almost_empty),
    .transmit_underrun_condition (transmit_underrun_condition),
    .audio_irq                   (audio_irq)
);
`default_nettype wire

// [tb_top.sv]
`timescale 1ns/100ps
`default_nettype none
module tb_top;
logic sys_clk=0,reset=1,reg_wr=0,rx=0,ov=0,ta=0,un=0,audio_irq;
logic[15:0]reg_wdata=0,x,reg_rdata;
int n_errors=0,num_checks=0,i;
aip_irq_pending_clear aip_irq_pending_clear_i(.sys_clk,.reset,.reg_wr,.reg_wdata,.reg_rdata,.audio_irq,
.receive_event(rx),.receive_overrun_condition(ov),.transmit_almost_empty(ta),.transmit_underrun_condition(un));
initial forever #2 sys_clk=~sys_clk;
task summarize;
$display("%0d %0d",num_checks,n_errors);
if(n_errors==0&&num_checks>0)$display("[ PASS ]");
else $display("[ FAIL ]");
$finish;
endtask
task s(logic e,logic[15:0]d,logic[3:0]m);
@(negedge sys_clk){reg_wr,reg_wdata,un,ta,ov,rx}={e,d,m};
@(negedge sys_clk){reg_wr,un,ta,ov,rx}=0;
endtask
task c(logic[15:0]v,string t);
@(negedge sys_clk)num_checks++;
if(reg_rdata!==v||audio_irq!==|v[7:4])begin n_errors++;$display("wrong value %0t %s",$time,t);end
$display(t);
endtask
initial begin
repeat(5)@(negedge sys_clk);reset=0;
c(16'h0000,"rst");
s(0,0,4'hF);c(16'h0000,"off");
s(1,16'h00FF,0);c(16'h000F,"ro");
s(0,0,4'hF);c(16'h00FF,"set");
x=16'h00FF;
for(i=0;i<4;i++)begin x[4+i]=0;s(1,16'h000F|16'h0100<<i,0);c(x,"clr");end
s(1,16'h010F,1);c(16'h001F,"both");
s(1,16'h0104,0);c(16'h0004,"tx_only");
s(0,0,4'hF);c(16'h0044,"tx_gate");
s(1,16'h0402,0);c(16'h0002,"rxe_only");
s(0,0,4'hF);c(16'h0022,"rxe_gate");
@(negedge sys_clk)reset=1;
c(16'h0000,"in_rst");
reset=0;
c(16'h0000,"rst2");
s(0,0,4'hF);c(16'h0000,"rst_en");
summarize;
end
endmodule // tb_top
`default_nettype wire
